/* File: common/uirpc_pkg.sv */
// Shared constants for the infrared pulse codec block
`default_nettype none
package uirpc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_DBG  = 8'h0B;
   localparam logic [7:0] IDX_EVT  = 8'h0C;
   localparam logic [7:0] IDX_TXPW = 8'h0D;
   localparam logic [7:0] IDX_RXPF = 8'h0E;
   localparam logic [7:0] IDX_CTRL = 8'h0F;
   localparam logic [7:0] IDX_STAT = 8'h10;

   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
   localparam logic [23:0] PAD_HI   = 24'h00_0000;

   // Field positions
   localparam int DBG_RUN_BIT   = 0;
   localparam int EVT_SEL_BIT   = 0;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RECEIVER_SWITCH_ON_BIT = 2;
   localparam int CTRL_EVSRC_BIT = 3;
   localparam int CTRL_LOOP_BIT = 4;
   localparam int CTRL_HDX_BIT  = 5;

   // Communication modes
   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_SYNC  = 2'h1;
   localparam logic [1:0] MODE_IR    = 2'h2;
   localparam logic [1:0] MODE_MSPI  = 2'h3;

   // Pulse width field codes
   localparam logic [7:0] TXPW_316  = 8'h00;
   localparam logic [7:0] TXPW_PASS = 8'hFF;
   localparam logic [6:0] RXPF_OFF  = 7'h00;

   // Sampling
   localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
   localparam logic [3:0] SAMPLE_LAST     = 4'hF;
   localparam logic [7:0] PULSE_316_SAMPLES = 8'h03;
   localparam logic [7:0] DIV_ZERO = 8'h00;

   // Maps a register index to its byte address
   function automatic logic [7:0] byteAddr(input logic [7:0] idx);
      byteAddr = {idx[5:0], 2'b00};
   endfunction : byteAddr
endpackage : uirpc_pkg
`default_nettype wire

/* File: hdl/uirpc_tx_mod.sv */
// Transmit pulse shaper: 3/16 bit or fixed clock count pulses
`timescale 1ns/1ns
`default_nettype none
module uirpc_tx_mod
   import uirpc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       run,
   input  wire logic       sampleTick,
   input  wire logic       baudTick,
   input  wire logic       txBit,
   input  wire logic [7:0] widthField,
   output logic            txLine
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       fixedMode;
   logic       passMode;
   logic       startPulse;
   logic       pulseOn;
   logic       decNow;

   assign passMode   = (widthField == TXPW_PASS);
   assign fixedMode  = (widthField != TXPW_316) && !passMode;
   // Zero bits are sent as pulses, always launched on a baud edge
   assign startPulse = run && baudTick && !txBit && !passMode;
   assign pulseOn    = (cnt_q != DIV_ZERO);
   // Fixed widths count clocks, the 3/16 width counts samples
   assign decNow     = run && pulseOn && (fixedMode || sampleTick);
   assign cnt_d = startPulse ? (fixedMode ? widthField : PULSE_316_SAMPLES)
                : decNow     ? cnt_q - 8'h01
                :              cnt_q;
   // Pulse drives the line low; pass-through hands the bit over as is
   assign txLine = passMode ? txBit : !pulseOn;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= DIV_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   AST_TX_316: assert property (@(posedge clk) disable iff (!arst_n)
      startPulse && !fixedMode |=> cnt_q == PULSE_316_SAMPLES)
      else $error("3/16 pulse not loaded with three samples");
   AST_TX_FIXED: assert property (@(posedge clk) disable iff (!arst_n)
      startPulse && fixedMode |=> pulseOn && cnt_q == $past(widthField))
      else $error("Fixed pulse length not loaded");
   AST_TX_ALIGN: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(pulseOn) |-> $past(baudTick))
      else $error("Pulse started off a baud edge");
endmodule : uirpc_tx_mod
`default_nettype wire

/* File: hdl/uirpc_rx_filt.sv */
// Receive pulse filter and demodulator
`timescale 1ns/1ns
`default_nettype none
module uirpc_rx_filt
   import uirpc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       run,
   input  wire logic       sampleTick,
   input  wire logic       active,
   input  wire logic       rxIn,
   input  wire logic [6:0] len,
   output logic            rxOut
);
   logic [7:0] lowCnt_q;
   logic [7:0] lowCnt_d;
   logic [4:0] hold_q;
   logic [4:0] hold_d;
   logic       tick;
   logic       holding;
   logic       accept;

   assign tick    = run && sampleTick && active;
   assign holding = (hold_q != 5'h00);
   // Accept on the len+1-th consecutive low sample; len 0 takes any
   assign accept  = tick && !holding && !rxIn && (lowCnt_q >= {1'b0, len});
   assign lowCnt_d = !tick            ? lowCnt_q
                   : (holding || rxIn || accept) ? DIV_ZERO
                   : lowCnt_q + 8'h01;
   assign hold_d = accept             ? SAMPLES_PER_BIT
                 : (tick && holding)  ? hold_q - 5'h01
                 :                      hold_q;
   // A rejected pulse leaves the line idle; an accepted one is a zero bit
   assign rxOut = active ? !holding : rxIn;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lowCnt_q <= DIV_ZERO;
         hold_q   <= 5'h00;
      end else begin
         lowCnt_q <= lowCnt_d;
         hold_q   <= hold_d;
      end
   end

   AST_RX_ACCEPT: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(holding) |-> $past(lowCnt_q) >= {1'b0, $past(len)} && !$past(rxIn))
      else $error("Pulse accepted before enough samples");
   AST_RX_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(holding) |-> hold_q == SAMPLES_PER_BIT && !rxOut)
      else $error("Accepted pulse not held as a full zero bit");
endmodule : uirpc_rx_filt
`default_nettype wire

/* File: hdl/uirpc_top.sv */
// Infrared pulse codec top: APB registers, sample timing and routing
`timescale 1ns/1ns
`default_nettype none
module uirpc_top
   import uirpc_pkg::*;
#(
   parameter logic [7:0] SAMPLE_DIV = 8'h04
)
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        dbgHalt,
   input  wire logic        txData,
   input  wire logic        txActive,
   input  wire logic        irRxIn,
   input  wire logic        eventIn,
   output logic             irTxOut,
   output logic             rxDataOut
);
   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic        runDbg_q;
   logic        evDis_q;
   logic [7:0]  txWidth_q;
   logic [6:0]  rxLen_q;
   logic [1:0]  commMode_q;
   logic        receiver_switch_on_q;
   logic        evSrc_q;
   logic        loop_q;
   logic        hdx_q;

   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;

   logic [7:0]  divCnt_q;
   logic [7:0]  divCnt_d;
   logic [3:0]  sampleIdx_q;
   logic [3:0]  sampleIdx_d;

   logic        irTx_q;
   logic        rxData_q;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   logic        access;
   logic        firstAccess;
   logic        wrStrobe;
   logic        hitDbg;
   logic        hitEvt;
   logic        hitTxpw;
   logic        hitRxpf;
   logic        hitCtrl;
   logic        hitStat;
   logic        hitAny;
   logic [7:0]  ctrlByte;
   logic [7:0]  statByte;
   logic [7:0]  rdByte;

   assign access      = psel && penable;
   assign firstAccess = access && !pready_q;
   // Writes land only on the completing edge
   assign wrStrobe    = access && pready_q && pwrite;

   assign hitDbg  = (paddr == byteAddr(IDX_DBG));
   assign hitEvt  = (paddr == byteAddr(IDX_EVT));
   assign hitTxpw = (paddr == byteAddr(IDX_TXPW));
   assign hitRxpf = (paddr == byteAddr(IDX_RXPF));
   assign hitCtrl = (paddr == byteAddr(IDX_CTRL));
   assign hitStat = (paddr == byteAddr(IDX_STAT));
   assign hitAny  = hitDbg || hitEvt || hitTxpw || hitRxpf || hitCtrl || hitStat;

   assign ctrlByte = {2'b00, hdx_q, loop_q, evSrc_q, receiver_switch_on_q, commMode_q};

   ////////////////////////////////////////////////////////////////////////////
   // Mode and run control
   logic        runEn;
   logic        halted;
   logic        irMode;
   logic        irCoded;
   logic        sampleTick;
   logic        baudTick;

   // Halt stops timing, shaping and line outputs unless the run bit is set; registers stay writable
   assign runEn   = !dbgHalt || runDbg_q;
   assign halted  = !runEn;
   assign irMode  = (commMode_q == MODE_IR);
   assign irCoded = irMode && (txWidth_q != TXPW_PASS);

   assign statByte = {4'h0, irMode, irTx_q, rxData_q, halted};
   assign rdByte   = hitDbg  ? {7'h00, runDbg_q}
                   : hitEvt  ? {7'h00, evDis_q}
                   : hitTxpw ? txWidth_q
                   : hitRxpf ? {1'b0, rxLen_q}
                   : hitCtrl ? ctrlByte
                   : hitStat ? statByte
                   :           RST_BYTE;

   ////////////////////////////////////////////////////////////////////////////
   // Sample and baud timing
   // The divider is frozen while halted, so no sample is taken then
   assign sampleTick  = runEn && (divCnt_q == DIV_ZERO);
   assign baudTick    = sampleTick && (sampleIdx_q == SAMPLE_LAST);
   assign divCnt_d    = !runEn      ? divCnt_q
                      : sampleTick  ? SAMPLE_DIV - 8'h01
                      :               divCnt_q - 8'h01;
   assign sampleIdx_d = sampleTick ? sampleIdx_q + 4'h1 : sampleIdx_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         divCnt_q    <= DIV_ZERO;
         sampleIdx_q <= 4'h0;
      end else begin
         divCnt_q    <= divCnt_d;
         sampleIdx_q <= sampleIdx_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive routing
   logic        evLive;
   logic        rxSrc;
   logic        filtOut;
   logic        rxLine;
   logic        txLine;
   logic        txMod;

   // A disabled event input, or one seen during halt without the run bit, reads as idle
   assign evLive = (evDis_q || halted) ? 1'b1 : eventIn;
   // Routing works in every width setting, pass-through included
   assign rxSrc  = loop_q               ? irTx_q
                 : (hdx_q && txActive)  ? 1'b1
                 : evSrc_q              ? evLive
                 :                        irRxIn;

   uirpc_rx_filt u_rxFilt (
      .clk        (clk),
      .arst_n     (arst_n),
      .run        (runEn && receiver_switch_on_q),
      .sampleTick (sampleTick),
      .active     (irCoded),
      .rxIn       (rxSrc),
      .len        (rxLen_q),
      .rxOut      (filtOut)
   );

   assign rxLine = filtOut;

   ////////////////////////////////////////////////////////////////////////////
   // Transmit path
   uirpc_tx_mod u_txMod (
      .clk        (clk),
      .arst_n     (arst_n),
      .run        (runEn),
      .sampleTick (sampleTick),
      .baudTick   (baudTick),
      .txBit      (txData),
      .widthField (txWidth_q),
      .txLine     (txMod)
   );

   // Outside infrared mode the bit goes out unshaped
   assign txLine = irMode ? txMod : txData;

   // Line outputs hold their level while the unit is halted
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irTx_q   <= 1'b1;
         rxData_q <= 1'b1;
      end else if (runEn) begin
         irTx_q   <= txLine;
         rxData_q <= rxLine;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         runDbg_q <= 1'b0;
         evDis_q  <= 1'b0;
      end else if (wrStrobe) begin
         if (hitDbg) begin
            runDbg_q <= pwdata[DBG_RUN_BIT];
         end
         if (hitEvt) begin
            evDis_q <= pwdata[EVT_SEL_BIT];
         end
      end
   end

   // Filter length is used live; it is meant to be set before receive on
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txWidth_q <= RST_BYTE;
         rxLen_q   <= RXPF_OFF;
      end else if (wrStrobe) begin
         if (hitTxpw) begin
            txWidth_q <= pwdata[7:0];
         end
         if (hitRxpf) begin
            rxLen_q <= pwdata[6:0];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         commMode_q <= MODE_ASYNC;
         receiver_switch_on_q     <= 1'b0;
         evSrc_q    <= 1'b0;
         loop_q     <= 1'b0;
         hdx_q      <= 1'b0;
      end else if (wrStrobe && hitCtrl) begin
         commMode_q <= pwdata[CTRL_MODE_LSB +: 2];
         receiver_switch_on_q     <= pwdata[CTRL_RECEIVER_SWITCH_ON_BIT];
         evSrc_q    <= pwdata[CTRL_EVSRC_BIT];
         loop_q     <= pwdata[CTRL_LOOP_BIT];
         hdx_q      <= pwdata[CTRL_HDX_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, read data captured with pready
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= RD_ZERO;
      end else begin
         pready_q  <= firstAccess;
         pslverr_q <= firstAccess && !hitAny;
         prdata_q  <= (firstAccess && !pwrite) ? {PAD_HI, rdByte} : RD_ZERO;
      end
   end

   assign prdata    = prdata_q;
   assign pready    = pready_q;
   assign pslverr   = pslverr_q;
   assign irTxOut   = irTx_q;
   assign rxDataOut = rxData_q;

   ////////////////////////////////////////////////////////////////////////////
   // Check helpers
   // Counts samples since the last baud edge apart from sampleIdx_q,
   // so a broken sample index shows up as a wrong count
   logic [4:0]  samplesSeen_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         samplesSeen_q <= 5'h00;
      end else if (baudTick) begin
         samplesSeen_q <= 5'h00;
      end else if (sampleTick) begin
         samplesSeen_q <= samplesSeen_q + 5'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Halt checks look one cycle on only at state, since halt may end then
   AST_HALT_FREEZE: assert property (@(posedge clk) disable iff (!arst_n)
      dbgHalt && !runDbg_q |=> $stable(irTx_q) && $stable(rxData_q) && $stable(divCnt_q))
      else $error("Unit kept running during debug halt");
   AST_HALT_NO_SAMPLE: assert property (@(posedge clk) disable iff (!arst_n)
      dbgHalt && !runDbg_q |-> !sampleTick && !baudTick)
      else $error("Sample taken during debug halt");
   AST_RUN_IN_HALT: assert property (@(posedge clk) disable iff (!arst_n)
      (dbgHalt && runDbg_q)[*8] |-> ##[0:255] sampleTick)
      else $error("Unit stopped in halt with run bit set");
   AST_EVT_GATE: assert property (@(posedge clk) disable iff (!arst_n)
      evSrc_q && !loop_q && !(hdx_q && txActive) && (evDis_q || halted) |-> rxSrc)
      else $error("Disabled event input reached the receiver");
   AST_TX_PASS: assert property (@(posedge clk) disable iff (!arst_n)
      runEn && txWidth_q == TXPW_PASS |=> irTx_q == $past(txData))
      else $error("Pass-through altered the transmit bit");
   AST_RX_PASS: assert property (@(posedge clk) disable iff (!arst_n)
      runEn && !irCoded |=> rxData_q == $past(rxSrc))
      else $error("Receive path altered outside coded infrared mode");
   AST_LOOPBACK: assert property (@(posedge clk) disable iff (!arst_n)
      runEn && loop_q && !irCoded |=> rxData_q == $past(irTx_q))
      else $error("Loop-back did not route transmit to receive");
   AST_BAUD16: assert property (@(posedge clk) disable iff (!arst_n)
      baudTick |-> sampleTick && samplesSeen_q == {1'b0, SAMPLE_LAST})
      else $error("Baud edge not on the sixteenth sample");
   AST_IR_MODE: assert property (@(posedge clk) disable iff (!arst_n)
      runEn && commMode_q != MODE_IR |=> irTx_q == $past(txData))
      else $error("Transmit shaped outside infrared mode");
   AST_APB_ONE_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
      psel && !penable ##1 psel && penable |=> pready_q)
      else $error("APB answer not one cycle into the access phase");
   AST_APB_STANDS: assert property (@(posedge clk) disable iff (!arst_n)
      pready_q |=> !pready_q)
      else $error("APB ready held longer than one cycle");
   AST_APB_ERR_WITH_READY: assert property (@(posedge clk) disable iff (!arst_n)
      pslverr_q |-> pready_q)
      else $error("APB error shown without ready");
   AST_APB_RDATA_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      !pready_q |-> prdata_q == RD_ZERO)
      else $error("Read data not zero outside the answer cycle");

   // Register storage and routing
   AST_EVT_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      wrStrobe && hitEvt |=> evDis_q == $past(pwdata[EVT_SEL_BIT]))
      else $error("Event input select not stored");
   AST_RUN_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      wrStrobe && hitDbg |=> runDbg_q == $past(pwdata[DBG_RUN_BIT]))
      else $error("Run-in-halt bit not stored");
   AST_HDX_MASK: assert property (@(posedge clk) disable iff (!arst_n)
      hdx_q && txActive && !loop_q |-> rxSrc)
      else $error("Half-duplex let the receive line through while sending");
   AST_STAT_HALT: assert property (@(posedge clk) disable iff (!arst_n)
      firstAccess && !pwrite && hitStat |=> prdata_q[0] == $past(halted))
      else $error("Status does not report the halt state");
endmodule : uirpc_top
`default_nettype wire

/* File: tb/uirpc_ir_xcvr.sv */
// Behavioural infrared transceiver facing the codec pins
`timescale 1ns/1ns
`default_nettype none
module uirpc_ir_xcvr (
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic        go,
   input  wire logic [7:0]  pulseLen,
   input  wire logic        irTxOut,
   output logic             irRxIn,
   output logic [15:0]      txLowCnt,
   output logic [15:0]      fallGap
);
   logic [7:0]  rxCnt;
   logic [15:0] gapCnt;
   logic        prevTx;

   ////////////////////////////////////////////////////////////////////////////
   // Receiver optics idle high once the pulse count has run down to zero; go starts a low pulse of pulseLen clocks
   assign irRxIn = (rxCnt == 8'h00);

   always @(posedge clk) begin
      prevTx <= irTxOut;
      if (go) begin
         rxCnt <= pulseLen;
      end else if (rxCnt != 8'h00) begin
         rxCnt <= rxCnt - 8'h01;
      end
      if (clr) begin
         txLowCnt <= 16'h0000;
         gapCnt   <= 16'h0000;
         fallGap  <= 16'h0000;
      end else begin
         if (!irTxOut) begin
            txLowCnt <= txLowCnt + 16'h0001;
         end
         // Spacing of pulse starts tells whether they follow the baud edges
         if (prevTx && !irTxOut) begin
            fallGap <= gapCnt;
            gapCnt  <= 16'h0001;
         end else begin
            gapCnt <= gapCnt + 16'h0001;
         end
      end
   end

   initial begin
      rxCnt  = 8'h00;
      prevTx = 1'b1;
   end
endmodule : uirpc_ir_xcvr
`default_nettype wire

/* File: tb/uirpc_top_tb_top.sv */
// Self-checking testbench for the infrared pulse codec
`timescale 1ns/1ns
`default_nettype none
module uirpc_top_tb_top;
   import uirpc_pkg::*;
   logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        dbgHalt, txData, txActive, irRxIn, eventIn, irTxOut, rxDataOut;
   logic        clr, go;
   logic [7:0]  paddr, pulseLen;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] txLowCnt, fallGap, rxLowCnt;
   logic [7:0]  widths [2] = '{8'h01, 8'h3F};
   int          mismatches, nCompared;

   uirpc_top #(.SAMPLE_DIV(8'h04)) dut_u (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dbgHalt(dbgHalt),
      .txData(txData), .txActive(txActive), .irRxIn(irRxIn), .eventIn(eventIn),
      .irTxOut(irTxOut), .rxDataOut(rxDataOut));

   uirpc_ir_xcvr xcvr_u (.clk(clk), .clr(clr), .go(go), .pulseLen(pulseLen),
      .irTxOut(irTxOut), .irRxIn(irRxIn), .txLowCnt(txLowCnt), .fallGap(fallGap));

   always @(posedge clk) begin
      if (clr) begin
         rxLowCnt <= 16'h0000;
      end else if (!rxDataOut) begin
         rxLowCnt <= rxLowCnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= adr;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Completion is whenever pready shows; only the watchdog bounds the wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic clear();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask : clear

   // Holds the serial bit low for n clocks, then lets pulses finish
   task automatic txWin(input int n);
      clear();
      txData <= 1'b0;
      repeat (n) @(posedge clk);
      txData <= 1'b1;
      repeat (80) @(posedge clk);
   endtask : txWin

   task automatic rxPulse(input logic [7:0] n);
      clear();
      pulseLen <= n;
      go       <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (120) @(posedge clk);
   endtask : rxPulse

   task automatic evPulse(input int n);
      clear();
      eventIn <= 1'b0;
      repeat (n) @(posedge clk);
      eventIn <= 1'b1;
      repeat (20) @(posedge clk);
   endtask : evPulse

   // Filter length goes in while the receiver is off
   task automatic rxCfg(input logic [1:0] mode, input logic [7:0] len);
      apb(1'b1, 8'h3C, {30'h0, mode});
      apb(1'b1, 8'h38, {24'h0, len});
      apb(1'b1, 8'h3C, {29'h0, 1'b1, mode});
   endtask : rxCfg

   task automatic report_and_stop();
      $display("mismatches %0d compared %0d", mismatches, nCompared);
      if (mismatches == 0 && nCompared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end

   initial begin
      {arst_n, psel, penable, pwrite, dbgHalt, txActive, clr, go} = 8'h00;
      {txData, eventIn} = 2'b11;
      {paddr, pulseLen, pwdata} = 48'h0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, 8'h2C + 8'(4 * i), 32'h0);
         chk(rd, 32'h0000_0000);
      end
      apb(1'b1, 8'h34, 32'hFFFF_FFA5);
      apb(1'b0, 8'h34, 32'h0);
      chk(rd, 32'h0000_00A5);
      apb(1'b1, 8'h38, 32'h0000_00FF);
      apb(1'b0, 8'h38, 32'h0);
      chk(rd, 32'h0000_007F);
      apb(1'b0, 8'h44, 32'h0);
      chk({rd[30:0], err}, 32'h0000_0001);
      // Only the infrared code shortens a low bit to a pulse
      apb(1'b1, 8'h34, 32'h0);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 8'h3C, 32'(m));
         txWin(64);
         chk(txLowCnt, (m == 2) ? 32'd12 : 32'd64);
      end
      apb(1'b1, 8'h3C, 32'h0000_0002);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 8'h34, {24'h0, widths[i]});
         txWin(64);
         chk(txLowCnt, {24'h0, widths[i]});
      end
      apb(1'b1, 8'h34, 32'h0000_0005);
      txWin(128);
      chk({txLowCnt, fallGap}, {16'd10, 16'd64});
      apb(1'b1, 8'h34, 32'h0000_00FF);
      txWin(64);
      chk(txLowCnt, 32'd64);
      // Receive filter: boundary below and at the accepted count
      apb(1'b1, 8'h34, 32'h0);
      rxCfg(2'h2, 8'h03);
      rxPulse(8'd12);
      chk(rxLowCnt, 32'd0);
      rxPulse(8'd16);
      chk(rxLowCnt, 32'd64);
      rxCfg(2'h2, 8'h00);
      rxPulse(8'd4);
      chk(rxLowCnt, 32'd64);
      rxCfg(2'h0, 8'h03);
      rxPulse(8'd8);
      chk(rxLowCnt, 32'd8);
      // Pass-through keeps the routing paths usable
      apb(1'b1, 8'h34, 32'h0000_00FF);
      rxCfg(2'h2, 8'h03);
      rxPulse(8'd8);
      chk(rxLowCnt, 32'd8);
      apb(1'b1, 8'h3C, 32'h0000_0026);
      apb(1'b0, 8'h3C, 32'h0);
      chk(rd, 32'h0000_0026);
      txActive <= 1'b1;
      rxPulse(8'd8);
      chk(rxLowCnt, 32'd0);
      txActive <= 1'b0;
      apb(1'b1, 8'h3C, 32'h0000_0016);
      txWin(10);
      chk(rxLowCnt, 32'd10);
      apb(1'b1, 8'h3C, 32'h0000_000E);
      evPulse(10);
      chk(rxLowCnt, 32'd10);
      apb(1'b1, 8'h30, 32'h0000_0001);
      evPulse(10);
      chk(rxLowCnt, 32'd0);
      apb(1'b1, 8'h30, 32'h0);
      // Halt with and without the run bit; no bus traffic while halted
      for (int r = 0; r < 2; r++) begin
         apb(1'b1, 8'h2C, 32'(r));
         dbgHalt <= 1'b1;
         txWin(64);
         chk(txLowCnt, r ? 32'd64 : 32'd0);
         evPulse(10);
         chk(rxLowCnt, r ? 32'd10 : 32'd0);
         dbgHalt <= 1'b0;
      end
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0000_000E);
      report_and_stop();
   end
endmodule : uirpc_top_tb_top
`default_nettype wire
